// ===== common/bus_ctl_pkg.sv
// Package of constants and types for the bus direction and reset control block
// Behaviour
// RULE1 - Select single-ended or differential operation from the differential mode select pin.
// RULE2 - In single-ended operation the initiator and target direction gates stay unused.
// RULE3 - Differential arbitration and selection: drive only own ID bit on data outputs; code does so only while the arbitration bit is set.
// RULE4 - Differential information transfer: data outputs all high for output, all low input.
// RULE5 - Initiator role: initiator direction gate steers ATN and ACK transceivers.
// RULE6 - Target role: target direction gate steers REQ, MSG, C/D and I/O transceivers.
// RULE7 - Busy, select and bus reset transceivers each enabled by own active-low output.
// RULE8 - With feature enable set, hold enables inactive two to three cycles after release.
// RULE9 - Input-to-output delays data-in activity; output-to-input delays data-out lines.
// RULE10 - Asynchronous send: data stands at least one period and 55 ns before strobe.
// RULE11 - Synchronous period is input clock scaled by the encoded period setting.
// RULE12 - Fast bus timing and fast clock bits select fast or normal synchronous timing.
// RULE13 - Software uses DMA for synchronous transfers; clears fast timing at 5.0 MB/s or below.
// RULE14 - Hard reset on power-up, chip-reset command or reset pin; device left disconnected.
// RULE15 - After chip-reset command all stays in reset until a no-operation command; code does not clear or hold the bus reset interrupt flag.
// RULE16 - Soft reset on bus reset sense or bus-reset command; command drives reset output.
// RULE17 - Soft reset clears sequencer, mode bits, command queue, bus signals except reset out.
// RULE18 - Received bus reset disconnects and raises interrupt unless disabled by config bit.
// RULE19 - Bus reset still sensed when interrupt cleared raises the interrupt again.
// RULE20 - Bus-reset command drives reset output about 25 us, no completion interrupt.
// RULE21 - Disconnect reset on disconnect commands, bus free as initiator, selection time-out.
// RULE22 - Disconnect reset clears mode bits, queue, bus signals except reset out, modules.
// RULE23 - Reset pulse and turnaround delay are counted in cycles of the one input clock.
package bus_ctl_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_PERIOD_PS    = 5000;
	localparam int SETUP_TIME_PS    = 55000;
	localparam int SETUP_CYCLES     = (SETUP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BUS_RESET_NS     = 25000;
	localparam int BUS_RESET_CYCLES = (BUS_RESET_NS * 1000) / CLK_PERIOD_PS;
	localparam int TURN_MIN_CYCLES  = 2;
	localparam int TURN_MAX_CYCLES  = 3;
	localparam int CNT_W            = 16;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_COMMAND = 8'h00;
	localparam logic [7:0] OFS_CONFIG  = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0C;
	localparam logic [7:0] OFS_INTCLR  = 8'h10;

	// ****************************************
	// Config field positions and reset value
	// ****************************************
	localparam int CFG_PERIOD_LSB   = 0;
	localparam int CFG_PERIOD_W     = 3;
	localparam int CFG_FAST_CLK     = 3;
	localparam int CFG_FAST_BUS     = 4;
	localparam int CFG_FEATURE_EN   = 6;
	localparam int CFG_RST_INT_DIS  = 7;
	localparam int CFG_OWN_ID_LSB   = 8;
	localparam logic [10:0] CFG_RESET = 11'h000;

	// ****************************************
	// Control and status bit positions
	// ****************************************
	localparam int CTL_SEL_EN    = 0;
	localparam int CTL_TARGET    = 1;
	localparam int CTL_INITIATOR = 2;
	localparam int CTL_BSY       = 3;
	localparam int CTL_SEL       = 4;
	localparam int CTL_ARB       = 5;
	localparam int CTL_DRIVE     = 6;
	localparam logic [6:0] CTL_RESET = 7'h00;
	localparam int ST_RST_INT    = 0;
	localparam int ST_DIFF       = 1;
	localparam int ST_LOCKED     = 2;
	localparam int ST_RST_OUT    = 3;
	localparam int ST_QUEUE      = 4;

	// ****************************************
	// Commands
	// ****************************************
	localparam logic [7:0] CMD_NOP        = 8'h00;
	localparam logic [7:0] CMD_CHIP_RESET = 8'h02;
	localparam logic [7:0] CMD_BUS_RESET  = 8'h03;
	localparam logic [7:0] CMD_TGT_DISC   = 8'h27;
	localparam logic [7:0] CMD_DISC_SEQ   = 8'h24;
	localparam logic [7:0] CMD_TERM_SEQ   = 8'h11;

	typedef enum logic [1:0] {DIR_IN, DIR_TURN_OUT, DIR_OUT, DIR_TURN_IN} dir_state_t;
endpackage

// ===== design/turnaround_timer.sv
// Direction turnaround delay for the differential transceivers
module turnaround_timer
	import bus_ctl_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic feature_en,
	input  wire logic want_out,
	output logic      drive_out,
	output logic      drive_in
);
	typedef struct packed {
		dir_state_t state;
		logic [1:0] cnt;
	} turn_t;

	turn_t cur_ff;
	turn_t nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		case (cur_ff.state)
			DIR_IN: begin
				if (want_out) begin
					nxt_cur.state = feature_en ? DIR_TURN_OUT : DIR_OUT; // [RULE8]
					nxt_cur.cnt   = 2'(TURN_MIN_CYCLES);
				end
			end
			DIR_TURN_OUT: begin
				nxt_cur.cnt = cur_ff.cnt - 2'd1;
				if (cur_ff.cnt == 2'd1) begin
					nxt_cur.state = DIR_OUT; // [RULE9]
				end
			end
			DIR_OUT: begin
				if (!want_out) begin
					nxt_cur.state = feature_en ? DIR_TURN_IN : DIR_IN; // [RULE8]
					nxt_cur.cnt   = 2'(TURN_MIN_CYCLES);
				end
			end
			DIR_TURN_IN: begin
				nxt_cur.cnt = cur_ff.cnt - 2'd1;
				if (cur_ff.cnt == 2'd1) begin
					nxt_cur.state = DIR_IN; // [RULE9]
				end
			end
			default: nxt_cur.state = DIR_IN;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cur_ff <= '{state: DIR_IN, cnt: 2'd0};
		end else begin
			cur_ff <= nxt_cur; // [RULE23]
		end
	end

	assign drive_out = (cur_ff.state == DIR_OUT);
	assign drive_in  = (cur_ff.state == DIR_IN);
endmodule

// ===== design/sync_period_gen.sv
// Synchronous transfer period generator and asynchronous setup timer
module sync_period_gen
	import bus_ctl_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	input  wire logic                    run,
	input  wire logic [CFG_PERIOD_W-1:0] period_code,
	input  wire logic                    fast_bus,
	input  wire logic                    fast_clk,
	output logic                         sync_tick,
	output logic                         setup_done
);
	typedef struct packed {
		logic [4:0] div;
		logic [4:0] setup;
		logic       tick;
	} per_t;

	per_t cur_ff;
	per_t nxt_cur;
	logic [4:0] limit;

	always_comb begin
		limit = 5'd4 + 5'(period_code); // [RULE11]
		if (fast_bus && fast_clk) begin
			limit = limit - 5'd2; // [RULE12]
		end else if (fast_bus || fast_clk) begin
			limit = limit - 5'd1; // [RULE12]
		end
		nxt_cur = cur_ff;
		nxt_cur.tick = 1'b0;
		if (!run) begin
			nxt_cur.div   = 5'd0;
			nxt_cur.setup = 5'd0;
		end else begin
			if (cur_ff.setup != 5'(SETUP_CYCLES)) begin
				nxt_cur.setup = cur_ff.setup + 5'd1; // [RULE10]
			end
			if (cur_ff.div >= limit) begin
				nxt_cur.div  = 5'd0;
				nxt_cur.tick = 1'b1;
			end else begin
				nxt_cur.div = cur_ff.div + 5'd1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign sync_tick  = cur_ff.tick;
	assign setup_done = (cur_ff.setup == 5'(SETUP_CYCLES)); // [RULE10]
endmodule

// ===== design/bus_ctl.sv
// Bus direction and three-level reset control with AXI4-Lite registers
module bus_ctl
	import bus_ctl_pkg::*;
#(
	parameter int RESET_CYCLES = BUS_RESET_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	input  wire logic        hw_reset_pin,
	input  wire logic        diff_mode_select_n,
	input  wire logic        bus_reset_sense_n,
	input  wire logic        bus_free,
	input  wire logic        select_timeout,
	input  wire logic [7:0]  bus_data_in_n,
	output logic [7:0]       bus_data_out_n,
	output logic             bus_parity_out_n,
	output logic [7:0]       data_drive,
	output logic             initiator_dir_gate,
	output logic             target_dir_gate,
	output logic             busy_drive_n,
	output logic             select_drive_n,
	output logic             bus_reset_drive_n,
	output logic             sync_tick,
	output logic             setup_done,
	output logic             bus_reset_irq
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [10:0]      cfg;
		logic [6:0]       ctl;
		logic [1:0]       queue;
		logic             locked;
		logic             rst_int;
		logic             sense_d;
		logic [CNT_W-1:0] rst_cnt;
		logic             aw_got;
		logic             w_got;
		logic [7:0]       aw_addr;
		logic [31:0]      w_data;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
		logic [7:0]       dout;
		logic             pout;
	} state_t;

	state_t cur_ff;
	state_t nxt_cur;

	logic diff_mode;
	logic turn_out;
	logic turn_in;
	logic drive_data;
	logic sense_rst;
	logic do_write;
	logic soft_rst;
	logic disc_rst;
	logic rst_irq_set;
	logic [7:0] cmd;
	logic [7:0] id_mask;

	function automatic logic is_disc_cmd(input logic [7:0] c);
		is_disc_cmd = (c == CMD_TGT_DISC) || (c == CMD_DISC_SEQ) || (c == CMD_TERM_SEQ);
	endfunction

	// ****************************************
	// Helpers
	// ****************************************
	turnaround_timer u_turn (
		.ref_clk   (ref_clk),
		.rst       (rst || hw_reset_pin), // [RULE14]
		.feature_en(cur_ff.cfg[CFG_FEATURE_EN]),
		.want_out  (drive_data),
		.drive_out (turn_out),
		.drive_in  (turn_in)
	);

	sync_period_gen u_sync (
		.ref_clk    (ref_clk),
		.rst        (rst || hw_reset_pin), // [RULE14]
		.run        (turn_out),
		.period_code(cur_ff.cfg[CFG_PERIOD_LSB +: CFG_PERIOD_W]),
		.fast_bus   (cur_ff.cfg[CFG_FAST_BUS]),
		.fast_clk   (cur_ff.cfg[CFG_FAST_CLK]),
		.sync_tick  (sync_tick),
		.setup_done (setup_done)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		diff_mode  = !diff_mode_select_n; // [RULE1]
		sense_rst  = !bus_reset_sense_n;
		drive_data = cur_ff.ctl[CTL_DRIVE] || cur_ff.ctl[CTL_ARB];
		id_mask    = 8'h01 << cur_ff.cfg[CFG_OWN_ID_LSB +: 3];
		do_write   = cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid;
		cmd        = cur_ff.w_data[7:0];
		nxt_cur    = cur_ff;
		soft_rst   = 1'b0;
		disc_rst   = 1'b0;
		// Write channel capture in either order
		if (awvalid && !cur_ff.aw_got) begin
			nxt_cur.aw_got  = 1'b1;
			nxt_cur.aw_addr = awaddr;
		end
		if (wvalid && !cur_ff.w_got) begin
			nxt_cur.w_got  = 1'b1;
			nxt_cur.w_data = wdata;
		end
		if (cur_ff.bvalid && bready) begin
			nxt_cur.bvalid = 1'b0;
		end
		if (do_write) begin
			nxt_cur.aw_got = 1'b0;
			nxt_cur.w_got  = 1'b0;
			nxt_cur.bvalid = 1'b1;
			nxt_cur.bresp  = 2'b00;
			if (cur_ff.aw_addr == OFS_COMMAND) begin
				if (wstrb[0]) begin
					if (cur_ff.locked) begin
						if (cmd == CMD_NOP) begin
							nxt_cur.locked = 1'b0; // [RULE15]
						end
					end else if (cmd == CMD_CHIP_RESET) begin
						nxt_cur.locked = 1'b1; // [RULE14]
					end else if (cmd == CMD_BUS_RESET) begin
						nxt_cur.rst_cnt = CNT_W'(RESET_CYCLES); // [RULE16] [RULE20]
						soft_rst = 1'b1;
					end else if (is_disc_cmd(cmd)) begin
						disc_rst = 1'b1; // [RULE21]
					end else if (cur_ff.queue != 2'd3) begin
						nxt_cur.queue = cur_ff.queue + 2'd1;
					end
				end
			end else if (cur_ff.locked) begin
				nxt_cur.bresp = 2'b00;
			end else if (cur_ff.aw_addr == OFS_CONFIG) begin
				nxt_cur.cfg = cur_ff.w_data[10:0];
			end else if (cur_ff.aw_addr == OFS_CONTROL) begin
				nxt_cur.ctl = cur_ff.w_data[6:0];
			end else if (cur_ff.aw_addr == OFS_INTCLR) begin
				if (cur_ff.w_data[ST_RST_INT]) begin
					nxt_cur.rst_int = 1'b0;
				end
			end else if (cur_ff.aw_addr != OFS_STATUS) begin
				nxt_cur.bresp = 2'b10;
			end
		end
		// Bus reset received
		nxt_cur.sense_d = sense_rst;
		if (sense_rst && !cur_ff.sense_d) begin
			soft_rst = 1'b1; // [RULE16] [RULE18]
		end
		rst_irq_set = sense_rst && !cur_ff.cfg[CFG_RST_INT_DIS]; // [RULE18] [RULE19]
		if (rst_irq_set) begin
			nxt_cur.rst_int = 1'b1;
		end
		// Bus free in initiator role, selection time-out
		if ((bus_free && cur_ff.ctl[CTL_INITIATOR]) || select_timeout) begin
			disc_rst = 1'b1; // [RULE21]
		end
		if (cur_ff.rst_cnt != '0) begin
			nxt_cur.rst_cnt = cur_ff.rst_cnt - CNT_W'(1); // [RULE23]
		end
		if (soft_rst) begin
			nxt_cur.ctl   = CTL_RESET; // [RULE17]
			nxt_cur.queue = 2'd0;
		end
		if (disc_rst) begin
			nxt_cur.ctl[CTL_TARGET]    = 1'b0; // [RULE22]
			nxt_cur.ctl[CTL_INITIATOR] = 1'b0;
			nxt_cur.ctl[CTL_BSY]       = 1'b0;
			nxt_cur.ctl[CTL_SEL]       = 1'b0;
			nxt_cur.ctl[CTL_ARB]       = 1'b0;
			nxt_cur.ctl[CTL_DRIVE]     = 1'b0;
			nxt_cur.queue              = 2'd0;
		end
		if (cur_ff.locked) begin
			nxt_cur.cfg   = CFG_RESET; // [RULE15]
			nxt_cur.ctl   = CTL_RESET;
			nxt_cur.queue = 2'd0;
			nxt_cur.rst_cnt = '0;
		end
		// Read channel
		if (cur_ff.rvalid && rready) begin
			nxt_cur.rvalid = 1'b0;
		end
		if (arvalid && !cur_ff.rvalid) begin
			nxt_cur.rvalid = 1'b1;
			nxt_cur.rresp  = 2'b00;
			nxt_cur.rdata  = 32'h0;
			if (araddr == OFS_CONFIG) begin
				nxt_cur.rdata[10:0] = cur_ff.cfg;
			end else if (araddr == OFS_CONTROL) begin
				nxt_cur.rdata[6:0] = cur_ff.ctl;
			end else if (araddr == OFS_STATUS) begin
				nxt_cur.rdata[ST_RST_INT]        = cur_ff.rst_int;
				nxt_cur.rdata[ST_DIFF]           = diff_mode;
				nxt_cur.rdata[ST_LOCKED]         = cur_ff.locked;
				nxt_cur.rdata[ST_RST_OUT]        = (cur_ff.rst_cnt != '0);
				nxt_cur.rdata[ST_QUEUE +: 2]     = cur_ff.queue;
			end else if ((araddr != OFS_COMMAND) && (araddr != OFS_INTCLR)) begin
				nxt_cur.rresp = 2'b10;
			end
		end
		// Data output lines
		nxt_cur.pout = 1'b1;
		if (!diff_mode) begin
			nxt_cur.dout = 8'hFF;
		end else if (turn_in) begin
			nxt_cur.dout = 8'h00; // [RULE4] [RULE9]
			nxt_cur.pout = 1'b0;
		end else if (cur_ff.ctl[CTL_ARB]) begin
			nxt_cur.dout = id_mask; // [RULE3]
			nxt_cur.pout = 1'b0;
		end else begin
			nxt_cur.dout = 8'hFF; // [RULE4] [RULE9]
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst || hw_reset_pin) begin
			cur_ff <= '0; // [RULE14]
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign awready = !cur_ff.aw_got;
	assign wready  = !cur_ff.w_got;
	assign bvalid  = cur_ff.bvalid;
	assign bresp   = cur_ff.bresp;
	assign arready = !cur_ff.rvalid;
	assign rvalid  = cur_ff.rvalid;
	assign rdata   = cur_ff.rdata;
	assign rresp   = cur_ff.rresp;
	assign bus_data_out_n   = cur_ff.dout;
	assign bus_parity_out_n = cur_ff.pout;
	assign data_drive = (diff_mode && turn_in) ? 8'h00 : // [RULE9]
		(turn_out ? (cur_ff.ctl[CTL_ARB] ? id_mask : 8'hFF) : 8'h00);
	assign initiator_dir_gate = diff_mode && cur_ff.ctl[CTL_INITIATOR]; // [RULE2] [RULE5]
	assign target_dir_gate    = diff_mode && cur_ff.ctl[CTL_TARGET]; // [RULE2] [RULE6]
	assign busy_drive_n      = !cur_ff.ctl[CTL_BSY]; // [RULE7]
	assign select_drive_n    = !cur_ff.ctl[CTL_SEL]; // [RULE7]
	assign bus_reset_drive_n = (cur_ff.rst_cnt == '0); // [RULE7] [RULE20]
	assign bus_reset_irq     = cur_ff.rst_int; // [RULE18]
endmodule

// ===== tb/bus_ctl_checker.sv
// Concurrent checks on the bus direction and reset control ports
module bus_ctl_checker
	import bus_ctl_pkg::*;
#(
	parameter int RESET_CYCLES = BUS_RESET_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hw_reset_pin,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic diff_mode_select_n,
	input wire logic bus_reset_sense_n,
	input wire logic bus_free,
	input wire logic select_timeout,
	input wire logic initiator_dir_gate,
	input wire logic target_dir_gate,
	input wire logic busy_drive_n,
	input wire logic select_drive_n,
	input wire logic bus_reset_drive_n,
	input wire logic sync_tick,
	input wire logic bus_reset_irq
);
	// Cycles the bus reset output has been low
	logic [CNT_W-1:0] low_ff;
	always_ff @(posedge ref_clk) begin
		if (rst || hw_reset_pin || bus_reset_drive_n) begin
			low_ff <= '0;
		end else begin
			low_ff <= low_ff + 1'b1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst || hw_reset_pin);
	sequence s_sense_held; !bus_reset_sense_n [*3]; endsequence
	sequence s_out_held; !bus_reset_drive_n [*3]; endsequence
	sequence s_pulse_end; $rose(bus_reset_drive_n); endsequence
	property p_se_gates;
		diff_mode_select_n && $past(diff_mode_select_n) |-> !initiator_dir_gate && !target_dir_gate;
	endproperty
	a_se_gates: assert property (p_se_gates) else $error("gate active in single-ended");
	property p_hard;
		disable iff (rst) hw_reset_pin |=> busy_drive_n && select_drive_n && bus_reset_drive_n
			&& !bus_reset_irq && !initiator_dir_gate && !target_dir_gate;
	endproperty
	a_hard: assert property (p_hard) else $error("hard reset left outputs active");
	property p_rst_len; !bus_reset_drive_n |-> low_ff <= RESET_CYCLES; endproperty
	a_rst_len: assert property (p_rst_len) else $error("bus reset pulse too long");
	property p_rst_end; s_pulse_end |-> low_ff >= RESET_CYCLES - 1; endproperty
	a_rst_end: assert property (p_rst_end) else $error("bus reset pulse too short");
	property p_irq_cause;
		$rose(bus_reset_irq) |-> !$past(bus_reset_sense_n) || !$past(bus_reset_sense_n, 2)
			|| !$past(bus_reset_sense_n, 3);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without bus reset");
	property p_sense_rel;
		s_sense_held |-> busy_drive_n && select_drive_n && !initiator_dir_gate && !target_dir_gate;
	endproperty
	a_sense_rel: assert property (p_sense_rel) else $error("signals held in bus reset");
	property p_out_rel; s_out_held |-> busy_drive_n && select_drive_n; endproperty
	a_out_rel: assert property (p_out_rel) else $error("signals held while resetting");
	property p_free; bus_free && initiator_dir_gate |-> ##[1:3] !initiator_dir_gate; endproperty
	a_free: assert property (p_free) else $error("initiator kept on bus free");
	property p_timeout;
		select_timeout |-> ##[1:3] (!target_dir_gate && !initiator_dir_gate);
	endproperty
	a_timeout: assert property (p_timeout) else $error("role kept on time-out");
	property p_tick; sync_tick |=> !sync_tick; endproperty
	a_tick: assert property (p_tick) else $error("sync tick longer than one cycle");
	property p_b_answer; awvalid && awready && wvalid && wready |-> ##[1:2] bvalid; endproperty
	a_b_answer: assert property (p_b_answer) else $error("write response missing");
endmodule

bind bus_ctl bus_ctl_checker #(.RESET_CYCLES(RESET_CYCLES)) bus_ctl_checker_i (
	.ref_clk(ref_clk), .rst(rst), .hw_reset_pin(hw_reset_pin), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
	.diff_mode_select_n(diff_mode_select_n), .bus_reset_sense_n(bus_reset_sense_n),
	.bus_free(bus_free), .select_timeout(select_timeout),
	.initiator_dir_gate(initiator_dir_gate), .target_dir_gate(target_dir_gate),
	.busy_drive_n(busy_drive_n), .select_drive_n(select_drive_n),
	.bus_reset_drive_n(bus_reset_drive_n), .sync_tick(sync_tick), .bus_reset_irq(bus_reset_irq)
);

// ===== tb/scsi_bus_model.sv
// Far-side bus device that answers or starts a bus reset
module scsi_bus_model (
	input  wire logic       ref_clk,
	input  wire logic       echo_en,
	input  wire logic       force_rst,
	input  wire logic       bus_reset_drive_n,
	output logic            bus_reset_sense_n,
	output logic [7:0]      bus_data_in_n
);
	timeunit 1ns;
	timeprecision 100ps;
	initial bus_reset_sense_n = 1'h1;
	initial bus_data_in_n = 8'hA5;
	// Other devices answer a driven reset or assert their own
	always @(posedge ref_clk) begin
		bus_reset_sense_n <= !(force_rst || (echo_en && !bus_reset_drive_n));
	end
	// Released data lines change every cycle
	always @(posedge ref_clk) begin
		bus_data_in_n <= ~bus_data_in_n + 8'h3C;
	end
endmodule

// ===== tb/bus_ctl_test.sv
// Self-checking bench for the bus direction and reset control block
module bus_ctl_test
	import bus_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RC = 20;
	typedef struct packed {
		logic dn;
		logic [10:0] cfg;
		logic [6:0] ctl;
		logic [3:0] o;
		logic [7:0] dd;
	} row_t;
	localparam row_t ROWS [8] = '{
		'{1'h1, 11'h000, 7'h04, 4'h3, 8'h00}, '{1'h1, 11'h000, 7'h02, 4'h3, 8'h00},
		'{1'h0, 11'h000, 7'h04, 4'hB, 8'h00}, '{1'h0, 11'h000, 7'h02, 4'h7, 8'h00},
		'{1'h0, 11'h000, 7'h18, 4'h0, 8'h00}, '{1'h0, 11'h500, 7'h20, 4'h3, 8'h20},
		'{1'h0, 11'h000, 7'h40, 4'h3, 8'hFF}, '{1'h0, 11'h000, 7'h00, 4'h3, 8'h00}};
	localparam logic [10:0] CODES [4] = '{11'h000, 11'h013, 11'h01F, 11'h00A};
	localparam logic [7:0] DISC [3] = '{CMD_TGT_DISC, CMD_DISC_SEQ, CMD_TERM_SEQ};
	logic        ref_clk = 1'h0, rst = 1'h1, hw_reset_pin = 1'h0, diff_mode_select_n = 1'h1;
	logic        awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
	logic        bus_free = 1'h0, select_timeout = 1'h0, echo_en = 1'h0, force_rst = 1'h0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, bus_data_in_n, bus_data_out_n, data_drive;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0]  wstrb = 4'hF;
	logic [1:0]  bresp, rresp, br, rr;
	logic        awready, wready, bvalid, arready, rvalid, bus_parity_out_n, bus_reset_irq;
	logic        initiator_dir_gate, target_dir_gate, busy_drive_n, select_drive_n;
	logic        bus_reset_drive_n, bus_reset_sense_n, sync_tick, setup_done;
	int          fails = 0, n_tests = 0, cyc = 0, n0, n1, s0, s1, m;

	bus_ctl #(.RESET_CYCLES(RC)) bus_ctl_i (
		.ref_clk(ref_clk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.hw_reset_pin(hw_reset_pin), .diff_mode_select_n(diff_mode_select_n),
		.bus_reset_sense_n(bus_reset_sense_n), .bus_free(bus_free),
		.select_timeout(select_timeout), .bus_data_in_n(bus_data_in_n),
		.bus_data_out_n(bus_data_out_n), .bus_parity_out_n(bus_parity_out_n),
		.data_drive(data_drive), .initiator_dir_gate(initiator_dir_gate),
		.target_dir_gate(target_dir_gate), .busy_drive_n(busy_drive_n),
		.select_drive_n(select_drive_n), .bus_reset_drive_n(bus_reset_drive_n),
		.sync_tick(sync_tick), .setup_done(setup_done), .bus_reset_irq(bus_reset_irq)
	);
	scsi_bus_model scsi_bus_model_i (
		.ref_clk(ref_clk), .echo_en(echo_en), .force_rst(force_rst),
		.bus_reset_drive_n(bus_reset_drive_n), .bus_reset_sense_n(bus_reset_sense_n),
		.bus_data_in_n(bus_data_in_n)
	);

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end

	// ****************************************
	// Bus tasks and checks
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic got = 1'h0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!got) begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			got = bvalid;
		end
		br = bresp;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge ref_clk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge ref_clk); while (!rvalid);
		v = rdata;
		rr = rresp;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask
	task automatic lag(input logic [10:0] cfg, output int n, output int s);
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_CONFIG, 32'(cfg));
		wr(OFS_CONTROL, 32'h40);
		n = 0;
		s = 0;
		for (int k = 0; k < 30; k++) begin
			if (data_drive !== 8'hFF) n++;
			if (setup_done !== 1'h1) s++;
			@(posedge ref_clk);
		end
	endtask
	task automatic gap(input logic [10:0] cfg, output int n);
		int k;
		lag(cfg, k, k);
		k = 0;
		while (!sync_tick && k < 40) begin
			@(posedge ref_clk);
			k++;
		end
		@(posedge ref_clk);
		n = 1;
		while (!sync_tick && n < 40) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		foreach (ROWS[i]) begin
			diff_mode_select_n <= ROWS[i].dn;
			wr(OFS_CONFIG, 32'(ROWS[i].cfg));
			wr(OFS_CONTROL, 32'(ROWS[i].ctl));
			repeat (4) @(posedge ref_clk);
			chk("gates", 32'(ROWS[i].o),
				32'({initiator_dir_gate, target_dir_gate, busy_drive_n, select_drive_n}));
			chk("data_drive", 32'(ROWS[i].dd), 32'(data_drive));
			chk("data_out", 32'(ROWS[i].dn ? 9'h1FF : {ROWS[i].dd, ROWS[i].dd == 8'hFF}),
				32'({bus_data_out_n, bus_parity_out_n}));
			rd(OFS_STATUS, d);
			chk("diff", 32'(!ROWS[i].dn), 32'(d[ST_DIFF]));
		end
		done("table");
		lag(11'h000, n0, s0);
		lag(11'h040, n1, s1);
		chk("turn_delay", 32'h2, 32'(n1 - n0));
		chk("setup", 1, 32'(s0 >= SETUP_CYCLES - 3 && s0 <= SETUP_CYCLES + 2));
		wr(OFS_CONTROL, 32'h0);
		@(posedge ref_clk);
		chk("drive_off", 0, 32'(data_drive));
		chk("out_hold", 32'hFF, 32'(bus_data_out_n));
		foreach (CODES[i]) begin
			gap(CODES[i], m);
			chk("period", 32'(5 + CODES[i][2:0] - CODES[i][4] - CODES[i][3]), 32'(m));
		end
		done("timing");
		wr(OFS_CONFIG, 32'h0);
		wr(OFS_CONTROL, 32'h0E);
		wr(OFS_COMMAND, 32'h01);
		wr(OFS_COMMAND, 32'(CMD_BUS_RESET));
		n0 = 0;
		while (bus_reset_drive_n === 1'h0 && n0 < 100) begin
			@(posedge ref_clk);
			n0++;
		end
		chk("rst_len", 1, 32'(n0 >= RC - 1 && n0 <= RC + 1));
		chk("no_irq", 0, 32'(bus_reset_irq));
		rd(OFS_CONTROL, d);
		chk("soft_clear", 0, d);
		rd(OFS_STATUS, d);
		chk("queue_empty", 0, 32'(d[ST_QUEUE +: 2]));
		echo_en <= 1'h1;
		wr(OFS_COMMAND, 32'(CMD_BUS_RESET));
		m = 0;
		while (bus_reset_irq !== 1'h1 && m < 15) begin
			@(posedge ref_clk);
			m++;
		end
		chk("irq_set", 1, 32'(bus_reset_irq));
		wr(OFS_INTCLR, 32'h1);
		@(posedge ref_clk);
		chk("irq_again", 1, 32'(bus_reset_irq));
		repeat (RC + 5) @(posedge ref_clk);
		echo_en <= 1'h0;
		wr(OFS_INTCLR, 32'h1);
		chk("irq_clr", 0, 32'(bus_reset_irq));
		wr(OFS_CONFIG, 32'h80);
		force_rst <= 1'h1;
		repeat (6) @(posedge ref_clk);
		chk("irq_off", 0, 32'(bus_reset_irq));
		force_rst <= 1'h0;
		done("soft_reset");
		wr(OFS_COMMAND, 32'(CMD_CHIP_RESET));
		rd(OFS_STATUS, d);
		chk("locked", 1, 32'(d[ST_LOCKED]));
		wr(OFS_CONTROL, 32'h08);
		chk("lock_hold", 1, 32'(busy_drive_n));
		wr(OFS_COMMAND, 32'(CMD_NOP));
		wr(OFS_CONTROL, 32'h08);
		chk("unlock", 0, 32'(busy_drive_n));
		hw_reset_pin <= 1'h1;
		@(posedge ref_clk);
		hw_reset_pin <= 1'h0;
		rd(OFS_CONTROL, d);
		chk("hw_reset", 0, d);
		done("hard_reset");
		for (int k = 0; k < 5; k++) begin
			wr(OFS_CONTROL, 32'h06);
			if (k < 3) wr(OFS_COMMAND, 32'(DISC[k]));
			else if (k == 3) bus_free <= 1'h1;
			else select_timeout <= 1'h1;
			@(posedge ref_clk);
			bus_free <= 1'h0;
			select_timeout <= 1'h0;
			repeat (3) @(posedge ref_clk);
			chk("disc_gates", 0, 32'({initiator_dir_gate, target_dir_gate}));
			rd(OFS_CONTROL, d);
			chk("disc_mode", 0, 32'(d[2:1]));
		end
		done("disconnect");
		wr(8'h14, 32'h1);
		chk("wr_unmapped", 2, 32'(br));
		rd(8'h14, d);
		chk("rd_unmapped", 2, 32'(rr));
		done("unmapped");
		stop_test();
	end
endmodule
